// ===== hdl/lds_i2c_port.sv
// Serial slave port with pointer, two registers and a crossing to the system clock.
`timescale 1ns/10ps
module lds_i2c_port
  import lds_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RSTN,
  input  wire logic       LINK_CLK,
  input  wire logic       EN,
  input  wire logic       SCL,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE_N,
  output logic            SLEEP_SELECT,
  output logic [7:0]      OUTPUT_LEVEL_CODE
);

  // ==========================================================================
  // Line conditioning on the link clock.
  logic [LINE_COUNT-1:0] raw_lines;
  logic [LINE_COUNT-1:0] filt_lines;
  logic                  scl_f;
  logic                  sda_f;
  logic                  en_f;
  logic                  prev_scl;
  logic                  prev_sda;

  assign raw_lines = {EN, SDA_IN, SCL};

  genvar gi;
  generate
    for (gi = 0; gi < LINE_COUNT; gi++) begin : g_line
      lds_line_filter #(
        .RESET_VALUE (LINE_RESET[gi])
      ) u_filter (
        .clk   (LINK_CLK),
        .rst_n (RSTN),
        .raw   (raw_lines[gi]),
        .filt  (filt_lines[gi])
      );
    end
  endgenerate

  assign scl_f = filt_lines[LINE_SCL];
  assign sda_f = filt_lines[LINE_SDA];
  assign en_f  = filt_lines[LINE_EN];

  always_ff @(posedge LINK_CLK or negedge RSTN) begin
    if (!RSTN) begin
      prev_scl <= 1'h1;
      prev_sda <= 1'h1;
    end else begin
      prev_scl <= scl_f;
      prev_sda <= sda_f;
    end
  end

  // ==========================================================================
  // Bus events.
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  assign scl_rise   = scl_f & ~prev_scl;
  assign scl_fall   = ~scl_f & prev_scl;
  assign start_seen = en_f & scl_f & prev_scl & prev_sda & ~sda_f;
  assign stop_seen  = en_f & scl_f & prev_scl & ~prev_sda & sda_f;

  // ==========================================================================
  // Engine state.
  lds_state_type state;
  lds_phase_type phase;
  logic [3:0]    bit_cnt;
  logic [7:0]    shreg;
  logic          read_mode;
  logic          nack;
  logic [7:0]    pointer;
  logic          sleep_reg;
  logic [7:0]    level_reg;
  logic [7:0]    read_data;
  logic          rx_done;
  logic          addr_match;
  logic          ack_end;
  logic          go_tx;
  logic          tx_last;
  logic          tx_next;
  logic          data_write;

  assign rx_done    = (state == ST_RX_BYTE) && scl_fall && (bit_cnt == RX_BITS);
  assign addr_match = (shreg[7:1] == SLAVE_ADDR);
  assign ack_end    = (state == ST_RX_ACK) && scl_fall;
  assign go_tx      = ack_end && read_mode && (phase == PH_PTR);
  assign tx_last    = (state == ST_TX_BYTE) && scl_fall && (bit_cnt == TX_LAST);
  assign tx_next    = (state == ST_TX_ACK) && scl_fall && !nack;
  assign data_write = rx_done && (phase == PH_DATA);

  always_comb begin
    case (pointer)
      REG_POWER_MODE:   read_data = {7'h00, sleep_reg};
      REG_OUTPUT_LEVEL: read_data = level_reg;
      default:          read_data = READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge LINK_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state   <= ST_IDLE;
      bit_cnt <= 4'h0;
    end else if (!en_f) begin
      state   <= ST_IDLE;
      bit_cnt <= 4'h0;
    end else if (start_seen) begin
      state   <= ST_RX_BYTE;
      bit_cnt <= 4'h0;
    end else if (stop_seen) begin
      state   <= ST_IDLE;
      bit_cnt <= 4'h0;
    end else begin
      case (state)
        ST_RX_BYTE: begin
          if (rx_done) begin
            bit_cnt <= 4'h0;
            state   <= (phase == PH_ADDR && !addr_match) ? ST_IGNORE : ST_RX_ACK;
          end else if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        ST_RX_ACK: begin
          if (ack_end) begin
            state <= go_tx ? ST_TX_BYTE : ST_RX_BYTE;
          end
        end
        ST_TX_BYTE: begin
          if (tx_last) begin
            state   <= ST_TX_ACK;
            bit_cnt <= 4'h0;
          end else if (scl_fall) begin
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        ST_TX_ACK: begin
          if (scl_fall) begin
            state <= nack ? ST_IGNORE : ST_TX_BYTE;
          end
        end
        ST_IGNORE: begin
          state <= ST_IGNORE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Shift register, byte role and direction.
  always_ff @(posedge LINK_CLK or negedge RSTN) begin
    if (!RSTN) begin
      shreg     <= 8'h00;
      phase     <= PH_ADDR;
      read_mode <= 1'h0;
      nack      <= 1'h1;
    end else if (!en_f || start_seen) begin
      phase     <= PH_ADDR;
      read_mode <= 1'h0;
    end else begin
      if (state == ST_RX_BYTE && scl_rise) begin
        shreg <= {shreg[6:0], sda_f};
      end else if (go_tx || tx_next) begin
        shreg <= read_data;
      end else if (state == ST_TX_BYTE && scl_fall) begin
        shreg <= {shreg[6:0], 1'h0};
      end
      if (rx_done && phase == PH_ADDR) begin
        read_mode <= (shreg[0] == DIR_READ);
        phase     <= PH_PTR;
      end else if (rx_done && phase == PH_PTR) begin
        phase <= PH_DATA;
      end
      if (state == ST_TX_ACK && scl_rise) begin
        nack <= sda_f;
      end
    end
  end

  // Register pointer.
  always_ff @(posedge LINK_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pointer <= POINTER_RESET;
    end else if (!en_f) begin
      pointer <= POINTER_RESET;
    end else if (rx_done && phase == PH_PTR) begin
      pointer <= shreg;
    end else if (data_write || tx_last) begin
      pointer <= pointer + 8'h01;
    end
  end

  // Registers, kept through sleep.
  always_ff @(posedge LINK_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sleep_reg <= SLEEP_RESET;
      level_reg <= LEVEL_RESET;
    end else if (!en_f) begin
      sleep_reg <= SLEEP_RESET;
      level_reg <= LEVEL_RESET;
    end else if (data_write && pointer == REG_POWER_MODE) begin
      sleep_reg <= shreg[SLEEP_BIT];
    end else if (data_write && pointer == REG_OUTPUT_LEVEL) begin
      level_reg <= shreg;
    end
  end

  // ==========================================================================
  // Open-drain data drive; the output level is always low.
  logic sda_drive;

  always_ff @(posedge LINK_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sda_drive <= 1'h0;
    end else if (!en_f || start_seen || stop_seen) begin
      sda_drive <= 1'h0;
    end else if (rx_done) begin
      sda_drive <= (phase != PH_ADDR) || addr_match;
    end else if (go_tx || tx_next) begin
      sda_drive <= ~read_data[7];
    end else if (ack_end || tx_last || (state == ST_TX_ACK && scl_fall)) begin
      sda_drive <= 1'h0;
    end else if (state == ST_TX_BYTE && scl_fall) begin
      sda_drive <= ~shreg[6];
    end
  end

  assign SDA_OUT  = 1'h0;
  assign SDA_OE_N = ~sda_drive;

  // ==========================================================================
  // Crossing of register values to the system clock by toggle handshake.
  logic       req_tgl;
  logic       ack_s1;
  logic       ack_s2;
  logic [8:0] shadow;
  logic       req_s1;
  logic       req_s2;
  logic       req_s3;
  logic       ack_tgl;

  always_ff @(posedge LINK_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ack_s1  <= 1'h0;
      ack_s2  <= 1'h0;
      req_tgl <= 1'h0;
      shadow  <= {SLEEP_RESET, LEVEL_RESET};
    end else begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
      if ((req_tgl == ack_s2) && (shadow != {sleep_reg, level_reg})) begin
        shadow  <= {sleep_reg, level_reg};
        req_tgl <= ~req_tgl;
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      req_s1            <= 1'h0;
      req_s2            <= 1'h0;
      req_s3            <= 1'h0;
      ack_tgl           <= 1'h0;
      SLEEP_SELECT      <= SLEEP_RESET;
      OUTPUT_LEVEL_CODE <= LEVEL_RESET;
    end else begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      if (req_s2 != req_s3) begin
        SLEEP_SELECT      <= shadow[8];
        OUTPUT_LEVEL_CODE <= shadow[7:0];
        ack_tgl           <= req_s2;
      end
    end
  end

  // ==========================================================================
  // Checks.
  sequence seq_ack_pulse;
    (state == ST_RX_ACK) && !SDA_OE_N;
  endsequence

  sequence seq_nack_end;
    (state == ST_TX_ACK) && nack && scl_fall && en_f && !start_seen && !stop_seen;
  endsequence

  AST_DRIVE_LOW_ONLY: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    !SDA_OE_N |-> (SDA_OUT == 1'h0))
    else $error("Data line driven to a high level.");

  AST_IDLE_RELEASED: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    (state == ST_IDLE) |-> SDA_OE_N)
    else $error("Data line held while bus idle.");

  AST_START_RESTART: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    start_seen |=> (state == ST_RX_BYTE) && (phase == PH_ADDR) && (bit_cnt == 4'h0) && $stable(pointer))
    else $error("START did not restart address reception.");

  AST_STOP_FREE: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    (stop_seen && !start_seen) |=> (state == ST_IDLE) && SDA_OE_N)
    else $error("STOP did not free the bus.");

  AST_ACK_HELD: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    (rx_done && en_f && !start_seen && !stop_seen && (phase != PH_ADDR || addr_match)) |=> seq_ack_pulse)
    else $error("Acknowledge not driven after a received byte.");

  AST_ACK_STAYS: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    (state == ST_RX_ACK) |-> seq_ack_pulse)
    else $error("Acknowledge released before the ninth pulse ended.");

  AST_HIGH_STABLE: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    (scl_f && prev_scl && en_f && !start_seen && !stop_seen) |=> $stable(SDA_OE_N))
    else $error("Data drive changed while clock high.");

  AST_FOREIGN_IGNORED: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    (rx_done && en_f && !start_seen && !stop_seen && phase == PH_ADDR && !addr_match) |=>
      (state == ST_IGNORE) && SDA_OE_N)
    else $error("Foreign address was answered.");

  AST_POINTER_LOAD: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    (rx_done && en_f && !start_seen && !stop_seen && phase == PH_PTR) |=>
      (pointer == $past(shreg)) && $stable(level_reg) && $stable(sleep_reg))
    else $error("Register address byte not taken as pointer.");

  AST_WRITE_STEP: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    (data_write && en_f && !start_seen && !stop_seen && pointer == REG_OUTPUT_LEVEL) |=>
      (level_reg == $past(shreg)) && (pointer == REG_OUTPUT_LEVEL + 8'h01))
    else $error("Data byte not stored with pointer step.");

  AST_READ_STEP: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    (tx_last && en_f && !start_seen && !stop_seen) |=> (pointer == $past(pointer) + 8'h01))
    else $error("Pointer did not advance after a sent byte.");

  AST_NACK_RELEASE: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    seq_nack_end |=> (state == ST_IGNORE) && SDA_OE_N)
    else $error("Data line not released after NACK.");

  AST_EN_RESET: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    !en_f |=> (state == ST_IDLE) && (level_reg == LEVEL_RESET) && (sleep_reg == SLEEP_RESET) && SDA_OE_N)
    else $error("Enable low did not hold the reset state.");

  AST_OUTPUT_TRANSFER: assert property (@(posedge CLK) disable iff (!RSTN)
    (req_s2 != req_s3) |=> ({SLEEP_SELECT, OUTPUT_LEVEL_CODE} == $past(shadow)))
    else $error("Register value not carried to the system clock.");

endmodule

// ===== hdl/lds_line_filter.sv
// Two-stage synchroniser followed by a glitch filter for one input line.
`timescale 1ns/10ps
module lds_line_filter
  import lds_pkg::*;
#(
  parameter logic RESET_VALUE = 1'h0
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic raw,
  output logic      filt
);

  // ==========================================================================
  // Synchroniser.
  logic       sync1;
  logic       sync2;
  logic [3:0] count;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= RESET_VALUE;
      sync2 <= RESET_VALUE;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end

  // ==========================================================================
  // Filter: the output follows only after the new level holds long enough.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 4'h0;
      filt  <= RESET_VALUE;
    end else if (sync2 == filt) begin
      count <= 4'h0;
    end else if (count == FILTER_LEN) begin
      count <= 4'h0;
      filt  <= sync2;
    end else begin
      count <= count + 4'h1;
    end
  end

  AST_FILTER_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(filt) |-> (filt == $past(sync2)) && ($past(sync2, 2) == filt))
    else $error("Filtered line changed without a held new level.");

endmodule

// ===== hdl/lds_pkg.sv
// Constants and types shared by the lens driver serial slave port.
package lds_pkg;

  // ==========================================================================
  // Bus addressing.
  localparam logic [7:0] DEV_ADDR_WRITE   = 8'hEC;
  localparam logic [7:0] DEV_ADDR_READ    = 8'hED;
  localparam logic [6:0] SLAVE_ADDR       = DEV_ADDR_WRITE[7:1];
  localparam logic       DIR_READ         = DEV_ADDR_READ[0];

  // ==========================================================================
  // Register map and reset values.
  localparam logic [7:0] REG_POWER_MODE   = 8'h00;
  localparam logic [7:0] REG_OUTPUT_LEVEL = 8'h01;
  localparam int         SLEEP_BIT        = 0;
  localparam logic       SLEEP_RESET      = 1'h0;
  localparam logic [7:0] LEVEL_RESET      = 8'h00;
  localparam logic [7:0] POINTER_RESET    = 8'h00;
  localparam logic [7:0] READ_UNMAPPED    = 8'h00;

  // ==========================================================================
  // Bit counting and line filtering.
  localparam logic [3:0] RX_BITS          = 4'h8;
  localparam logic [3:0] TX_LAST          = 4'h7;
  localparam logic [3:0] FILTER_LEN       = 4'h3;
  localparam int         LINE_SCL         = 0;
  localparam int         LINE_SDA         = 1;
  localparam int         LINE_EN          = 2;
  localparam int         LINE_COUNT       = 3;
  localparam logic [2:0] LINE_RESET       = 3'h3;

  // ==========================================================================
  // Engine states and byte roles.
  typedef enum logic [2:0] {ST_IDLE, ST_RX_BYTE, ST_RX_ACK, ST_TX_BYTE, ST_TX_ACK, ST_IGNORE} lds_state_type;
  typedef enum logic [1:0] {PH_ADDR, PH_PTR, PH_DATA} lds_phase_type;

endpackage

// ===== sim/lds_i2c_master.sv
// Behavioural two-wire bus master that drives the serial lines of the port.
`timescale 1ns/10ps
module lds_i2c_master (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_m
);
  // ==========================================================================
  // Line levels and phase timing.
  localparam int HALF = 8;

  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  task automatic pause();
    repeat (HALF) @(negedge clk);
  endtask

  // ==========================================================================
  // Framing conditions.
  task automatic start();
    sda_m = 1'b1;
    pause();
    scl = 1'b1;
    pause();
    sda_m = 1'b0;
    pause();
    scl = 1'b0;
    pause();
  endtask

  task automatic stop();
    sda_m = 1'b0;
    pause();
    scl = 1'b1;
    pause();
    sda_m = 1'b1;
    pause();
  endtask

  // ==========================================================================
  // Bits and bytes.
  task automatic clock_bit(input logic b, output logic s);
    sda_m = b;
    pause();
    scl = 1'b1;
    pause();
    s   = sda_line;
    scl = 1'b0;
    pause();
  endtask

  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(d[i], s);
    end
    clock_bit(1'b1, s);
    ack = ~s;
  endtask

  task automatic read_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, s);
      d[i] = s;
    end
    clock_bit(~ack, s);
  endtask
endmodule

// ===== sim/lens_driver_i2c_slave_port_tb.sv
// Self-checking bench of the serial slave port driven by a behavioural master.
`timescale 1ns/10ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
  $display("unexpected at %0t: value %h differs from %h", $time, got, exp); end end
module lens_driver_i2c_slave_port_tb
  import lds_pkg::*;
;
  // ==========================================================================
  // Signals, clocks and instances.
  typedef struct {logic [7:0] ptr; logic [7:0] data; logic sleep; logic [7:0] level; logic [7:0] rd;} lds_row_type;
  lds_row_type rows [6] = '{
    '{8'h00, 8'h01, 1'h1, 8'h00, 8'h01},
    '{8'h01, 8'hA5, 1'h1, 8'hA5, 8'hA5},
    '{8'h00, 8'hFE, 1'h0, 8'hA5, 8'h00},
    '{8'h01, 8'h5A, 1'h0, 8'h5A, 8'h5A},
    '{8'h00, 8'h03, 1'h1, 8'h5A, 8'h01},
    '{8'h05, 8'h77, 1'h1, 8'h5A, 8'h00}
  };
  logic [7:0] bad [4] = '{8'hEE, 8'hDC, 8'h6D, 8'hEF};
  int         err_count  = 0;
  int         n_compared = 0;
  logic       clk        = 1'b0;
  logic       link_clk;
  logic       rstn       = 1'b0;
  logic       en         = 1'b1;
  logic       mon_on     = 1'b0;
  logic       scl;
  logic       sda_m;
  logic       sda_oe_n;
  logic       sda_out;
  logic       sleep_select;
  logic [7:0] output_level_code;
  logic       bit_s;
  wire        sda_line   = sda_m & sda_oe_n;

  always #25 clk = ~clk;

  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end

  lds_i2c_port lds_i2c_port_inst (.CLK(clk), .RSTN(rstn), .LINK_CLK(link_clk), .EN(en), .SCL(scl),
    .SDA_IN(sda_line), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .SLEEP_SELECT(sleep_select),
    .OUTPUT_LEVEL_CODE(output_level_code));

  lds_i2c_master lds_i2c_master_inst (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));

  always @(sda_oe_n) begin
    if (mon_on) begin
      `CHK(scl, 1'b0)
    end
  end

  // ==========================================================================
  // Bus tasks and the closing report.
  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic ack;
    lds_i2c_master_inst.write_byte(b, ack);
    `CHK(ack, exp_ack)
  endtask

  task automatic set_ptr(input logic [7:0] p);
    lds_i2c_master_inst.start();
    send(DEV_ADDR_WRITE, 1'b1);
    send(p, 1'b1);
    lds_i2c_master_inst.stop();
  endtask

  task automatic get(input logic ack, input logic [7:0] exp);
    logic [7:0] v;
    lds_i2c_master_inst.read_byte(ack, v);
    `CHK(v, exp)
  endtask

  task automatic check_out(input logic s, input logic [7:0] l);
    repeat (10) @(negedge clk);
    `CHK(sleep_select, s)
    `CHK(output_level_code, l)
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    repeat (8) @(negedge clk);
    `CHK(sda_oe_n, 1'b1)
    `CHK(sleep_select, SLEEP_RESET)
    `CHK(output_level_code, LEVEL_RESET)
    rstn = 1'b1;
    check_out(SLEEP_RESET, LEVEL_RESET);
    mon_on = 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      lds_i2c_master_inst.start();
      send(DEV_ADDR_WRITE, 1'b1);
      send(rows[i].ptr, 1'b1);
      send(rows[i].data, 1'b1);
      lds_i2c_master_inst.stop();
      check_out(rows[i].sleep, rows[i].level);
      set_ptr(rows[i].ptr);
      lds_i2c_master_inst.start();
      send(DEV_ADDR_READ, 1'b1);
      get(1'b0, rows[i].rd);
      lds_i2c_master_inst.stop();
      $display("test row %0d done", i);
    end
    lds_i2c_master_inst.start();
    send(DEV_ADDR_WRITE, 1'b1);
    send(REG_POWER_MODE, 1'b1);
    send(8'h00, 1'b1);
    send(8'hC3, 1'b1);
    lds_i2c_master_inst.stop();
    check_out(1'b0, 8'hC3);
    set_ptr(REG_POWER_MODE);
    check_out(1'b0, 8'hC3);
    lds_i2c_master_inst.start();
    send(DEV_ADDR_READ, 1'b1);
    get(1'b1, 8'h00);
    get(1'b0, 8'hC3);
    `CHK(sda_oe_n, 1'b1)
    lds_i2c_master_inst.stop();
    $display("test burst done");
    foreach (bad[i]) begin
      lds_i2c_master_inst.start();
      send(bad[i], 1'b0);
      send(REG_OUTPUT_LEVEL, 1'b0);
      send(8'h11, 1'b0);
      lds_i2c_master_inst.stop();
    end
    check_out(1'b0, 8'hC3);
    $display("test foreign address done");
    lds_i2c_master_inst.start();
    send(DEV_ADDR_WRITE, 1'b1);
    send(REG_OUTPUT_LEVEL, 1'b1);
    lds_i2c_master_inst.clock_bit(1'b1, bit_s);
    lds_i2c_master_inst.clock_bit(1'b0, bit_s);
    lds_i2c_master_inst.clock_bit(1'b1, bit_s);
    lds_i2c_master_inst.start();
    send(DEV_ADDR_READ, 1'b1);
    get(1'b0, 8'hC3);
    lds_i2c_master_inst.stop();
    lds_i2c_master_inst.start();
    send(DEV_ADDR_WRITE, 1'b1);
    send(8'hFF, 1'b1);
    send(8'h44, 1'b1);
    send(8'h01, 1'b1);
    send(8'h66, 1'b1);
    lds_i2c_master_inst.stop();
    check_out(1'b1, 8'h66);
    $display("test restart and wrap done");
    mon_on = 1'b0;
    en = 1'b0;
    check_out(SLEEP_RESET, LEVEL_RESET);
    lds_i2c_master_inst.start();
    send(DEV_ADDR_WRITE, 1'b0);
    send(REG_POWER_MODE, 1'b0);
    send(8'h01, 1'b0);
    lds_i2c_master_inst.stop();
    check_out(SLEEP_RESET, LEVEL_RESET);
    en = 1'b1;
    repeat (10) @(negedge clk);
    lds_i2c_master_inst.start();
    send(DEV_ADDR_WRITE, 1'b1);
    send(REG_OUTPUT_LEVEL, 1'b1);
    send(8'h99, 1'b1);
    lds_i2c_master_inst.stop();
    check_out(1'b0, 8'h99);
    $display("test enable done");
    rstn = 1'b0;
    check_out(SLEEP_RESET, LEVEL_RESET);
    `CHK(sda_oe_n, 1'b1)
    `CHK(sda_out, 1'b0)
    rstn = 1'b1;
    repeat (10) @(negedge clk);
    lds_i2c_master_inst.start();
    send(DEV_ADDR_WRITE, 1'b1);
    send(REG_OUTPUT_LEVEL, 1'b1);
    send(8'h3C, 1'b1);
    lds_i2c_master_inst.stop();
    check_out(SLEEP_RESET, 8'h3C);
    $display("test second reset done");
    conclude();
  end
endmodule
